/* logic/stc_pkg.sv */
package stc_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h0e;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0f;
  localparam logic [7:0] ADDR_CONTROL    = 8'h10;
  localparam logic [7:0] ADDR_FLAG       = 8'h0c;
  localparam logic [7:0] ADDR_ENABLE     = 8'h8c;
  localparam logic [7:0] ADDR_PINS       = 8'h20;

  // Control, flag and enable register field positions.
  localparam int CTL_RUN    = 0;
  localparam int CTL_CS     = 1;
  localparam int CTL_SYNC_N = 2;
  localparam int CTL_OSCEN  = 3;
  localparam int CTL_PS_LO  = 4;
  localparam int CTL_PS_HI  = 5;
  localparam int FLAG_OVF   = 0;
  localparam int EN_OVF     = 0;

  // Values after reset, the control write mask and the count maximum.
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  CONTROL_MASK = 8'h3f;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // Clock arithmetic: instruction rate is one quarter of the oscillator rate.
  localparam int REF_CLK_MHZ  = 100;
  localparam int OSC_DIV      = 4;
  localparam logic [1:0] TICK_DIV_LAST = 2'(OSC_DIV - 1);

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stc_bus_s;

  typedef struct packed {
    logic osc_in_oe;
    logic osc_out_oe;
    logic osc_amp_on;
  } stc_pins_s;

endpackage

/* logic/stc_prescaler.sv */
`timescale 1ns/1ps
module stc_prescaler #(
  parameter int W = 3
) (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Control.
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [1:0] sel,
  // Result.
  output logic            fire
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] last;

  // Terminal count is 2^sel - 1, so codes give 1:1, 1:2, 1:4 and 1:8.
  assign last = W'((1 << sel) - 1);
  assign fire = tick && !clear && (cnt_q == last);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= (cnt_q == last) ? '0 : W'(cnt_q + 1'b1);
    end
  end

endmodule

/* logic/stc_timer.sv */
// Functional notes
// - Sixteen-bit count rises from 0000h to FFFFh, then wraps to zero.
// - Each wrap from FFFFh to zero sets the overflow flag, bit 0.
// - Interrupt request is raised only while overflow flag and enable are both set.
// - Control bit 1 selects timer mode (0) or external counter mode (1).
// - Timer mode counts one tick per instruction cycle, oscillator over four.
// - Counter mode counts each rising edge of the external input.
// - Control bit 0 runs counting when set, halts it when clear.
// - Compare unit trigger input clears the count.
// - Oscillator enable forces both oscillator pins to inputs, ignoring direction bits.
// - Prescale field 00,01,10,11 divides by 1,2,4,8.
// - Oscillator enable runs crystal amplifier; clear switches inverter off.
// - In counter mode, control bit 2 low synchronises, high leaves unsynchronised.
// - In timer mode the synchronisation bit has no effect.
// - After enabling counter mode, a falling edge must come before counting.
// - Any write to either count half clears the prescaler.
// - Compare trigger reset never sets the overflow flag.
// - Power-on reset clears the control register; other resets leave it.
// - Software count write wins over a coincident compare trigger.
`timescale 1ns/1ps
module stc_timer (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Register port.
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [7:0]            rdata,
  // Pins and neighbours.
  input  wire logic             ext_clk_pin,
  input  wire logic             osc_in_pin,
  input  wire logic [1:0]       port_direction_bits,
  input  wire logic             capture_compare_trigger,
  output logic                  irq,
  output logic                  osc_in_oe,
  output logic                  osc_out_oe,
  output logic                  osc_amp_on,
  output logic [15:0]           count
);

  stc_pkg::stc_bus_s  bus;
  stc_pkg::stc_pins_s pins_d;
  logic [7:0]  control_q;
  logic [15:0] count_q;
  logic        overflow_flag_q;
  logic        overflow_irq_enable_q;
  logic [1:0]  tick_div_q;
  logic        inst_tick;
  logic [2:0]  pin_sync_q;
  logic        pin_level_q;
  logic        pin_raw_q;
  logic        armed_q;
  logic        run_q;
  logic        sel_level;
  logic        ext_rise;
  logic        ext_fall;
  logic        ps_tick;
  logic        ps_fire;
  logic        count_wr;
  logic        wrap;
  logic [7:0]  rdata_d;
  logic        sync_n;
  logic        cs;
  logic        run;

  assign bus    = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign run    = control_q[stc_pkg::CTL_RUN];
  assign cs     = control_q[stc_pkg::CTL_CS];
  assign sync_n = control_q[stc_pkg::CTL_SYNC_N];

  // Power-on reset alone clears control; no other reset source reaches it.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_q <= stc_pkg::CONTROL_RST;
    end else if (bus.wr && bus.addr == stc_pkg::ADDR_CONTROL) begin
      control_q <= bus.wdata & stc_pkg::CONTROL_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq_enable_q <= 1'b0;
    end else if (bus.wr && bus.addr == stc_pkg::ADDR_ENABLE) begin
      overflow_irq_enable_q <= bus.wdata[stc_pkg::EN_OVF];
    end
  end

  // Instruction-cycle enable: one pulse every four reference clocks.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_div_q <= '0;
    end else begin
      tick_div_q <= (tick_div_q == stc_pkg::TICK_DIV_LAST) ? '0 : 2'(tick_div_q + 1'b1);
    end
  end
  assign inst_tick = (tick_div_q == stc_pkg::TICK_DIV_LAST);

  // The oscillator input replaces the count pin while the crystal runs.
  assign sel_level = control_q[stc_pkg::CTL_OSCEN] ? osc_in_pin : ext_clk_pin;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_q <= '0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], sel_level};
    end
  end

  // A level change counts only once the second and third stages agree.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_level_q <= 1'b0;
      pin_raw_q   <= 1'b0;
    end else begin
      pin_raw_q <= pin_sync_q[1];
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_level_q <= pin_sync_q[2];
      end
    end
  end

  // Unsynchronised mode skips the agreement filter, so edges land one cycle sooner.
  // The pin still passes the stages; a true asynchronous counter needs a second clock.
  assign ext_rise = sync_n ? (pin_sync_q[1] && !pin_raw_q)
                           : (pin_sync_q[2] && !pin_level_q && pin_sync_q[1]);
  assign ext_fall = sync_n ? (!pin_sync_q[1] && pin_raw_q)
                           : (!pin_sync_q[2] && pin_level_q && !pin_sync_q[1]);

  // Arming waits for a falling edge after counter mode is enabled.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q   <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      run_q <= run && cs;
      if (!(run && cs)) begin
        armed_q <= 1'b0;
      end else if (ext_fall) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Timer mode ignores the sync bit entirely.
  assign ps_tick = run && (cs ? (ext_rise && armed_q && run_q)
                              : inst_tick);

  assign count_wr = bus.wr && (bus.addr == stc_pkg::ADDR_COUNT_LOW ||
                               bus.addr == stc_pkg::ADDR_COUNT_HIGH);

  stc_prescaler #(
    .W(3)
  ) i_stc_prescaler (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (count_wr),
    .tick    (ps_tick),
    .sel     (control_q[stc_pkg::CTL_PS_HI:stc_pkg::CTL_PS_LO]),
    .fire    (ps_fire)
  );

  assign wrap = ps_fire && (count_q == stc_pkg::COUNT_MAX);

  // Write beats trigger, trigger beats increment.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= stc_pkg::COUNT_RST;
    end else if (count_wr) begin
      if (bus.addr == stc_pkg::ADDR_COUNT_LOW) begin
        count_q[7:0] <= bus.wdata;
      end else begin
        count_q[15:8] <= bus.wdata;
      end
    end else if (capture_compare_trigger) begin
      count_q <= stc_pkg::COUNT_RST;
    end else if (ps_fire) begin
      count_q <= 16'(count_q + 1'b1);
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag_q <= 1'b0;
    end else if (wrap && !count_wr && !capture_compare_trigger) begin
      overflow_flag_q <= 1'b1;
    end else if (bus.wr && bus.addr == stc_pkg::ADDR_FLAG) begin
      overflow_flag_q <= bus.wdata[stc_pkg::FLAG_OVF];
    end
  end

  always_comb begin
    unique case (bus.addr)
      stc_pkg::ADDR_COUNT_LOW:  rdata_d = count_q[7:0];
      stc_pkg::ADDR_COUNT_HIGH: rdata_d = count_q[15:8];
      stc_pkg::ADDR_CONTROL:    rdata_d = control_q;
      stc_pkg::ADDR_FLAG:       rdata_d = {7'h00, overflow_flag_q};
      stc_pkg::ADDR_ENABLE:     rdata_d = {7'h00, overflow_irq_enable_q};
      stc_pkg::ADDR_PINS:       rdata_d = {6'h00, pin_level_q, armed_q};
      default:                  rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= bus.rd ? rdata_d : 8'h00;
    end
  end

  // Pin drivers: the crystal owns both pins while it runs.
  always_comb begin
    pins_d.osc_amp_on = control_q[stc_pkg::CTL_OSCEN];
    pins_d.osc_in_oe  = control_q[stc_pkg::CTL_OSCEN] ? 1'b0 : !port_direction_bits[1];
    pins_d.osc_out_oe = control_q[stc_pkg::CTL_OSCEN] ? 1'b0 : !port_direction_bits[0];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq        <= 1'b0;
      osc_in_oe  <= 1'b0;
      osc_out_oe <= 1'b0;
      osc_amp_on <= 1'b0;
      count      <= stc_pkg::COUNT_RST;
    end else begin
      irq        <= overflow_flag_q && overflow_irq_enable_q;
      osc_in_oe  <= pins_d.osc_in_oe;
      osc_out_oe <= pins_d.osc_out_oe;
      osc_amp_on <= pins_d.osc_amp_on;
      count      <= count_q;
    end
  end

  property p_wrap_sets_flag;
    @(posedge ref_clk) disable iff (!arst_n)
      (wrap && !count_wr && !capture_compare_trigger) |=>
        overflow_flag_q && count_q == stc_pkg::COUNT_RST;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap missed flag");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (!arst_n)
      ##1 irq == $past(overflow_flag_q && overflow_irq_enable_q);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

  property p_trigger_clears;
    @(posedge ref_clk) disable iff (!arst_n)
      (capture_compare_trigger && !count_wr) |=> count_q == stc_pkg::COUNT_RST;
  endproperty
  a_trigger_clears: assert property (p_trigger_clears) else $error("trigger kept count");

  property p_trigger_no_flag;
    @(posedge ref_clk) disable iff (!arst_n)
      (capture_compare_trigger && !overflow_flag_q &&
       !(bus.wr && bus.addr == stc_pkg::ADDR_FLAG)) |=> !overflow_flag_q;
  endproperty
  a_trigger_no_flag: assert property (p_trigger_no_flag) else $error("trigger set flag");

  property p_write_wins;
    @(posedge ref_clk) disable iff (!arst_n)
      (capture_compare_trigger && bus.wr && bus.addr == stc_pkg::ADDR_COUNT_HIGH) |=>
        count_q[15:8] == $past(wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost");

  property p_halt;
    @(posedge ref_clk) disable iff (!arst_n)
      (!run && !count_wr && !capture_compare_trigger) |=> count_q == $past(count_q);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while halted");

  property p_timer_rate;
    @(posedge ref_clk) disable iff (!arst_n)
      (ps_fire && !cs) |-> ##1 !ps_fire [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer too fast");

  property p_unarmed;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(armed_q) |-> $past(ext_fall) && run_q;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("counted before falling edge");

  property p_osc_pins;
    @(posedge ref_clk) disable iff (!arst_n)
      control_q[stc_pkg::CTL_OSCEN] |=> !osc_in_oe && !osc_out_oe && osc_amp_on;
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("oscillator pins driven");

  property p_pins_follow;
    @(posedge ref_clk) disable iff (!arst_n)
      !control_q[stc_pkg::CTL_OSCEN] |=>
        !osc_amp_on && osc_out_oe != $past(port_direction_bits[0]);
  endproperty
  a_pins_follow: assert property (p_pins_follow) else $error("pins wrong");

  property p_count_step;
    @(posedge ref_clk) disable iff (!arst_n)
      (ps_fire && !count_wr && !capture_compare_trigger) |=>
        count_q == 16'($past(count_q) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_control_kept;
    @(posedge ref_clk) disable iff (!arst_n)
      !(bus.wr && bus.addr == stc_pkg::ADDR_CONTROL) |=> $stable(control_q);
  endproperty
  a_control_kept: assert property (p_control_kept) else $error("control moved");

endmodule

/* verification/stc_ext_src.sv */
`timescale 1ns/1ps
module stc_ext_src #(
  parameter int HALF = 5
) (
  // Clock.
  input  wire logic       ref_clk,
  // Command.
  input  wire logic       go,
  input  wire logic [7:0] n_edges,
  input  wire logic       rest,
  input  wire logic       use_osc,
  output logic            busy,
  // Pins.
  output logic            ext_clk_pin,
  output logic            osc_in_pin
);
  logic       lvl_q = 1'b0;
  logic [7:0] left_q = 8'h00;
  int         cnt_q = 0;

  // The source clock stands still between bursts, at the level asked for.
  always @(posedge ref_clk) begin
    if (left_q == 8'h00) begin
      if (go) begin
        left_q <= n_edges;
        cnt_q  <= HALF;
      end else begin
        lvl_q <= rest;
      end
    end else if (cnt_q <= 1) begin
      lvl_q  <= ~lvl_q;
      left_q <= left_q - 8'h01;
      cnt_q  <= HALF;
    end else begin
      cnt_q <= cnt_q - 1;
    end
  end

  assign busy        = (left_q != 8'h00);
  assign ext_clk_pin = use_osc ? 1'b0 : lvl_q;
  assign osc_in_pin  = use_osc ? lvl_q : 1'b0;
endmodule

/* verification/test_stc_timer.sv */
`timescale 1ns/1ps
module test_stc_timer;
  logic               ref_clk = 1'b0;
  logic               arst_n = 1'b0;
  stc_pkg::stc_bus_s  b = '0;
  stc_pkg::stc_pins_s pins;
  logic [1:0]         dir = 2'h0;
  logic               trig = 1'b0;
  logic               go = 1'b0;
  logic [7:0]         n_edges = 8'h00;
  logic               rest = 1'b0;
  logic               use_osc = 1'b0;
  logic               ext_clk_pin;
  logic               osc_in_pin;
  logic               busy;
  logic               irq;
  logic [7:0]         rdata;
  logic [15:0]        count;
  int                 n_errors = 0;
  int                 total_checks = 0;

  always #5 ref_clk = ~ref_clk;

  stc_timer i_stc_timer (
    .ref_clk(ref_clk), .arst_n(arst_n), .addr(b.addr), .wdata(b.wdata),
    .wr(b.wr), .rd(b.rd), .rdata(rdata), .ext_clk_pin(ext_clk_pin),
    .osc_in_pin(osc_in_pin), .port_direction_bits(dir), .capture_compare_trigger(trig),
    .irq(irq), .osc_in_oe(pins.osc_in_oe), .osc_out_oe(pins.osc_out_oe),
    .osc_amp_on(pins.osc_amp_on), .count(count));

  stc_ext_src i_stc_ext_src (
    .ref_clk(ref_clk), .go(go), .n_edges(n_edges), .rest(rest),
    .use_osc(use_osc), .busy(busy), .ext_clk_pin(ext_clk_pin),
    .osc_in_pin(osc_in_pin));

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    b <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    b.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    b <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    b.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulses(input logic [7:0] n);
    int k;
    @(posedge ref_clk);
    n_edges <= n;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    for (k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge ref_clk);
    if (k == 1000) begin
      n_errors++;
      conclude();
    end
  endtask

  initial begin
    logic [7:0] d;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    reg_rd(stc_pkg::ADDR_CONTROL, d);
    chk("control", {8'h00, d}, 16'h0000);
    reg_wr(8'h33, 8'h5a);
    reg_rd(8'h33, d);
    chk("unmapped", {8'h00, d}, 16'h0000);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'hfe);
    reg_rd(stc_pkg::ADDR_CONTROL, d);
    chk("control bits", {8'h00, d}, 16'h00fe & 16'h003f);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
    cyc(2);
    chk("pins", {13'h0, pins}, 16'h0006);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h08);
    cyc(2);
    chk("pins osc", {13'h0, pins}, 16'h0001);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
    cyc(2);
    chk("pins off", {13'h0, pins}, 16'h0006);
    @(posedge ref_clk);
    dir <= 2'h1;
    cyc(2);
    chk("pins dir", {13'h0, pins}, 16'h0004);
    // Divider phase is free, so each prescale allows one increment of slack.
    for (int i = 0; i < 8; i++) begin
      reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
      reg_wr(stc_pkg::ADDR_COUNT_LOW, 8'h00);
      reg_wr(stc_pkg::ADDR_COUNT_HIGH, 8'h00);
      reg_wr(stc_pkg::ADDR_CONTROL, {2'h0, 2'(i), 1'b0, i[2], 2'h1});
      cyc(32 << i[1:0]);
      reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
      cyc(2);
      chk("prescaled", {15'h0, count >= 16'h0007 && count <= 16'h0009}, 16'h0001);
    end
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h31);
    cyc(20);
    reg_wr(stc_pkg::ADDR_COUNT_LOW, 8'h00);
    reg_wr(stc_pkg::ADDR_COUNT_HIGH, 8'h00);
    cyc(20);
    chk("prescaler cleared", count, 16'h0000);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
    reg_wr(stc_pkg::ADDR_FLAG, 8'h00);
    reg_wr(stc_pkg::ADDR_ENABLE, 8'h00);
    reg_wr(stc_pkg::ADDR_COUNT_LOW, 8'hff);
    reg_wr(stc_pkg::ADDR_COUNT_HIGH, 8'hff);
    cyc(8);
    chk("halted", count, 16'hffff);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h01);
    cyc(10);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
    cyc(2);
    chk("wrapped", {15'h0, count < 16'h0004}, 16'h0001);
    reg_rd(stc_pkg::ADDR_FLAG, d);
    chk("flag", {8'h00, d}, 16'h0001);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    reg_wr(stc_pkg::ADDR_ENABLE, 8'h01);
    cyc(2);
    chk("irq", {15'h0, irq}, 16'h0001);
    reg_wr(stc_pkg::ADDR_FLAG, 8'h00);
    reg_wr(stc_pkg::ADDR_COUNT_LOW, 8'h55);
    @(posedge ref_clk);
    trig <= 1'b1;
    @(posedge ref_clk);
    trig <= 1'b0;
    cyc(2);
    chk("trigger clear", count, 16'h0000);
    reg_rd(stc_pkg::ADDR_FLAG, d);
    chk("flag kept", {8'h00, d}, 16'h0000);
    @(posedge ref_clk);
    b <= '{addr: stc_pkg::ADDR_COUNT_LOW, wdata: 8'h77, wr: 1'b1, rd: 1'b0};
    trig <= 1'b1;
    @(posedge ref_clk);
    b.wr <= 1'b0;
    trig <= 1'b0;
    cyc(2);
    chk("write wins", count, 16'h0077);
    // Both sync settings, on the plain pin and on the oscillator pin.
    for (int s = 0; s < 4; s++) begin
      reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
      reg_wr(stc_pkg::ADDR_COUNT_LOW, 8'h00);
      @(posedge ref_clk);
      rest <= 1'b1;
      use_osc <= s[1];
      cyc(8);
      reg_wr(stc_pkg::ADDR_CONTROL, {4'h0, s[1], s[0], 2'h3});
      pulses(8'd6);
      cyc(8);
      chk("edges", count, 16'h0003);
    end
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h00);
    reg_wr(stc_pkg::ADDR_COUNT_LOW, 8'h00);
    @(posedge ref_clk);
    rest <= 1'b0;
    use_osc <= 1'b0;
    cyc(8);
    reg_wr(stc_pkg::ADDR_CONTROL, 8'h03);
    pulses(8'd6);
    cyc(8);
    chk("first rise", count, 16'h0002);
    conclude();
  end
endmodule
